//--- src/pfd_regs.svh
// Purpose: register offsets, field positions and reset values of the entry decoder
// Assumes: byte addresses on a 32-bit Avalon-MM slave, word aligned
// Notes:   definitions only
`ifndef PFD_REGS_SVH
`define PFD_REGS_SVH

`define PFD_OFF_CFG        8'h00
`define PFD_OFF_ROOT_LO    8'h04
`define PFD_OFF_ROOT_HI    8'h08
`define PFD_OFF_CAP        8'h0c
`define PFD_OFF_STATUS     8'h10
`define PFD_OFF_MASK       8'h14
`define PFD_OFF_RESULT     8'h18

`define PFD_CFG_TTS_LSB    0
`define PFD_CFG_LVL_LSB    3
`define PFD_CFG_EAU_BIT    5
`define PFD_CFG_SXB_BIT    6
`define PFD_CFG_XDH_BIT    7
`define PFD_CFG_SWP_BIT    8
`define PFD_CFG_ERE_BIT    9
`define PFD_CFG_RPD_BIT    10
`define PFD_CFG_MASK       32'h0000_07ff
`define PFD_CFG_RESET      32'h0000_0000
`define PFD_ROOT_LO_MASK   32'hffff_f000
`define PFD_ROOT_RESET     52'h0_0000_0000_0000

`define PFD_ST_REMAP_BIT   0
`define PFD_ST_TRANS_BIT   1
`define PFD_ST_DONE_BIT    2
`define PFD_ST_RESET       3'h0
`define PFD_MASK_RESET     3'h0

`define PFD_LVL_FOUR       2'h0
`define PFD_LVL_FIVE       2'h1
`define PFD_DEPTH_FOUR     3'h4
`define PFD_DEPTH_FIVE     3'h5

`endif

//--- src/pfd_pkg.sv
// Purpose: types shared by the entry decoder
// Assumes: nothing beyond the register header
// Notes:   translation type codes follow the entry encoding
package pfd_pkg;

    typedef enum logic [2:0] {
        PFD_TT_FIRST  = 3'h1,
        PFD_TT_SECOND = 3'h2,
        PFD_TT_NESTED = 3'h3,
        PFD_TT_PASS   = 3'h4
    } pfd_tts_e;

    typedef enum logic [1:0] {
        PFD_BUS_IDLE = 2'h0,
        PFD_BUS_ACK  = 2'h1
    } pfd_bus_e;

    typedef logic [2:0] pfd_irq_t;

endpackage : pfd_pkg

//--- src/pfd_entry_decode.sv
// Purpose: first-stage controls of a process-address-space table entry, checked per request
// Assumes: entry fields loaded by software over Avalon-MM; walk summary from the page walker
// Notes:   one result per accepted check, one cycle after acceptance
// Summary of operation
// RULE_01: software writes reserved entry bits as zero
// RULE_02: root is four- or five-level top table base
// RULE_03: root ignored for second-stage-only and pass-through
// RULE_04: nested mode treats root as guest physical
// RULE_05: no first-stage support forces fields to zero
// RULE_06: enables ignored for second-stage-only and pass-through; the code still applies the execute requests enable (ere_en) in every type
// RULE_07: accessed-update enable sets extended accessed flags
// RULE_08: supervisor execute from user page faults
// RULE_09: execute-disable bit blocks fetch when enabled
// RULE_10: write protect ignored for user requests
// RULE_11: write protect blocks supervisor read-only writes
// RULE_12: level select 00 four, 01 five, else reserved
// RULE_13: execute requests blocked while execute enable clear
// RULE_14: bad level select reported as translation fault
`timescale 1ns/1ps
`default_nettype none
`include "pfd_regs.svh"

module pfd_entry_decode #(
    parameter bit FS_SUPPORTED  = 1'b1,
    parameter bit FL5_SUPPORTED = 1'b1,
    parameter bit EA_SUPPORTED  = 1'b1,
    parameter int ADDR_W        = 8
) (
    input  wire logic                mclk,
    input  wire logic                rst,
    input  wire logic [ADDR_W-1:0]   avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output logic [31:0]              avs_readdata,
    output logic                     avs_waitrequest,
    input  wire logic                chk_valid,
    output logic                     chk_ready,
    input  wire logic                chk_with_pasid,
    input  wire logic                chk_privileged,
    input  wire logic                chk_exec,
    input  wire logic                chk_write,
    input  wire logic                chk_walk_all_user,
    input  wire logic                chk_walk_any_xd,
    input  wire logic                chk_page_read_only,
    output logic                     res_valid,
    output logic                     res_remap_fault,
    output logic                     res_trans_fault,
    output logic                     res_root_used,
    output logic                     res_root_is_gpa,
    output logic [63:12]             res_root,
    output logic [2:0]               res_depth,
    output logic                     res_ea_update,
    output logic                     irq
);
    import pfd_pkg::*;

    if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr_w
        $error("pfd_entry_decode: ADDR_W must be 5 to 8");
    end

    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : be_merge

    // bus slave: one wait cycle, then answer
    pfd_bus_e          bus_state;
    pfd_bus_e          next_bus_state;
    logic [31:0]       cfg;
    logic [63:12]      root;
    pfd_irq_t          status;
    pfd_irq_t          mask;
    logic [31:0]       last_result;
    logic [7:0]        addr8;
    wire logic         bus_req   = avs_read | avs_write;
    wire logic         bus_done  = bus_req & (bus_state == PFD_BUS_ACK);
    wire logic         wr_en     = avs_write & bus_done;
    wire logic         hit_cfg   = addr8 == `PFD_OFF_CFG;
    wire logic         hit_rlo   = addr8 == `PFD_OFF_ROOT_LO;
    wire logic         hit_rhi   = addr8 == `PFD_OFF_ROOT_HI;
    wire logic         hit_st    = addr8 == `PFD_OFF_STATUS;
    wire logic         hit_mask  = addr8 == `PFD_OFF_MASK;
    wire logic [31:0]  cfg_wr    = be_merge(cfg, avs_writedata, avs_byteenable) & `PFD_CFG_MASK;
    wire logic [31:0]  rlo_wr    = be_merge({root[31:12], 12'h000}, avs_writedata,
                                            avs_byteenable) & `PFD_ROOT_LO_MASK;
    wire logic [31:0]  rhi_wr    = be_merge(root[63:32], avs_writedata, avs_byteenable);
    wire logic [31:0]  st_wr     = be_merge(32'h0000_0000, avs_writedata, avs_byteenable);
    wire logic [31:0]  mask_wr   = be_merge({29'h0000_0000, mask}, avs_writedata, avs_byteenable);
    wire logic [31:0]  cap_word  = {29'h0000_0000, EA_SUPPORTED, FL5_SUPPORTED, FS_SUPPORTED};
    logic [31:0]       rd_mux;

    assign addr8 = 8'(avs_address);
    assign avs_waitrequest = bus_req & (bus_state != PFD_BUS_ACK);
    assign next_bus_state  = (bus_req && bus_state == PFD_BUS_IDLE) ? PFD_BUS_ACK : PFD_BUS_IDLE;

    always_comb begin
        case (addr8)
            `PFD_OFF_CFG:     rd_mux = cfg;
            `PFD_OFF_ROOT_LO: rd_mux = {root[31:12], 12'h000};
            `PFD_OFF_ROOT_HI: rd_mux = root[63:32];
            `PFD_OFF_CAP:     rd_mux = cap_word;
            `PFD_OFF_STATUS:  rd_mux = {29'h0000_0000, status};
            `PFD_OFF_MASK:    rd_mux = {29'h0000_0000, mask};
            `PFD_OFF_RESULT:  rd_mux = last_result;
            default:          rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            bus_state    <= PFD_BUS_IDLE;
            avs_readdata <= 32'h0000_0000;
        end else begin
            bus_state    <= next_bus_state;
            avs_readdata <= (avs_read && bus_state == PFD_BUS_IDLE) ? rd_mux : avs_readdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cfg  <= `PFD_CFG_RESET;
            root <= `PFD_ROOT_RESET;
            mask <= `PFD_MASK_RESET;
        end else begin
            if (wr_en && hit_cfg) begin
                cfg <= cfg_wr;
            end
            if (wr_en && hit_rlo) begin
                root[31:12] <= rlo_wr[31:12];
            end
            if (wr_en && hit_rhi) begin
                root[63:32] <= rhi_wr;
            end
            if (wr_en && hit_mask) begin
                mask <= mask_wr[2:0];
            end
        end
    end

    // entry field decode
    wire logic [2:0]  tts_raw  = cfg[`PFD_CFG_TTS_LSB +: 3];
    wire logic [1:0]  lvl_raw  = cfg[`PFD_CFG_LVL_LSB +: 2];
    wire logic        tt_known = tts_raw == PFD_TT_FIRST || tts_raw == PFD_TT_SECOND
                               || tts_raw == PFD_TT_NESTED || tts_raw == PFD_TT_PASS;
    wire logic        fs_walk  = FS_SUPPORTED                                        // see RULE_05
                               && (tts_raw == PFD_TT_FIRST || tts_raw == PFD_TT_NESTED); // see RULE_03
    wire logic        lvl_bad  = lvl_raw[1] || (lvl_raw == `PFD_LVL_FIVE && !FL5_SUPPORTED); // see RULE_12
    wire logic        eau_en   = fs_walk && EA_SUPPORTED && cfg[`PFD_CFG_EAU_BIT];   // see RULE_06
    wire logic        sxb_en   = fs_walk && cfg[`PFD_CFG_SXB_BIT];                   // see RULE_06
    wire logic        xdh_en   = fs_walk && cfg[`PFD_CFG_XDH_BIT];                   // see RULE_06
    wire logic        swp_en   = fs_walk && cfg[`PFD_CFG_SWP_BIT];                   // see RULE_06
    wire logic        ere_en   = cfg[`PFD_CFG_ERE_BIT];
    wire logic        priv_eff = chk_with_pasid ? chk_privileged : cfg[`PFD_CFG_RPD_BIT];

    // request checks
    wire logic chk_fire   = chk_valid & chk_ready;
    wire logic f_trans    = !tt_known || (fs_walk && lvl_bad);                       // see RULE_14
    wire logic f_ere      = chk_with_pasid && chk_exec && !ere_en;                   // see RULE_13
    wire logic f_sxb      = sxb_en && priv_eff && chk_exec && chk_walk_all_user;     // see RULE_08
    wire logic f_xd       = xdh_en && chk_exec && chk_walk_any_xd;                   // see RULE_09
    wire logic f_wp       = swp_en && priv_eff && chk_write && chk_page_read_only;   // see RULE_10
    wire logic f_remap    = !f_trans && (f_ere || f_sxb || f_xd || f_wp);            // see RULE_11
    wire logic [2:0] dep  = (lvl_raw == `PFD_LVL_FIVE) ? `PFD_DEPTH_FIVE : `PFD_DEPTH_FOUR; // see RULE_02
    wire logic ev_remap   = res_valid & res_remap_fault;
    wire logic ev_trans   = res_valid & res_trans_fault;
    wire pfd_irq_t ev_vec = {res_valid, ev_trans, ev_remap};

    assign chk_ready = !rst;

    always_ff @(posedge mclk) begin
        if (rst) begin
            res_valid       <= 1'b0;
            res_remap_fault <= 1'b0;
            res_trans_fault <= 1'b0;
            res_root_used   <= 1'b0;
            res_root_is_gpa <= 1'b0;
            res_root        <= `PFD_ROOT_RESET;
            res_depth       <= `PFD_DEPTH_FOUR;
            res_ea_update   <= 1'b0;
        end else begin
            res_valid <= chk_fire;
            if (chk_fire) begin
                res_remap_fault <= f_remap;
                res_trans_fault <= f_trans;
                res_root_used   <= fs_walk && !f_trans;                         // see RULE_03
                res_root_is_gpa <= fs_walk && tts_raw == PFD_TT_NESTED;          // see RULE_04
                res_root        <= fs_walk ? root : `PFD_ROOT_RESET;             // see RULE_05
                res_depth       <= dep;
                res_ea_update   <= eau_en && !f_trans && !f_remap;               // see RULE_07
            end
        end
    end

    // sticky status, set wins over write-one-clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            status      <= `PFD_ST_RESET;
            last_result <= 32'h0000_0000;
        end else begin
            status <= (status & ~((wr_en && hit_st) ? st_wr[2:0] : 3'h0)) | ev_vec;
            if (res_valid) begin
                last_result <= {24'h00_0000, res_depth, res_ea_update, res_root_is_gpa,
                                res_root_used, res_trans_fault, res_remap_fault};
            end
        end
    end

    assign irq = |(status & mask);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_lvl_reserved: assert property (                                           // see RULE_14
        chk_fire && fs_walk && lvl_raw[1] |=> res_valid && res_trans_fault)
        else $error("reserved level select not faulted");
    a_five_level: assert property (                                             // see RULE_02
        chk_fire && fs_walk && lvl_raw == `PFD_LVL_FIVE && FL5_SUPPORTED
        |=> res_depth == 3'h5 && res_root_used && res_root == $past(root))
        else $error("five-level root not passed");
    a_four_level: assert property (                                             // see RULE_12
        chk_fire && lvl_raw == `PFD_LVL_FOUR |=> res_depth == 3'h4)
        else $error("four-level depth wrong");
    a_root_ignored: assert property (                                           // see RULE_03
        chk_fire && (tts_raw == PFD_TT_SECOND || tts_raw == PFD_TT_PASS)
        |=> !res_root_used && !res_root_is_gpa && !res_ea_update)
        else $error("root used in second-stage or pass-through");
    a_nested_gpa: assert property (                                             // see RULE_04
        chk_fire && FS_SUPPORTED && tts_raw == PFD_TT_NESTED |=> res_root_is_gpa)
        else $error("nested root not marked guest physical");
    a_no_fs: assert property (                                                  // see RULE_05
        chk_fire && !FS_SUPPORTED |=> !res_root_used && !res_ea_update)
        else $error("first-stage fields used without support");
    a_ea_update: assert property (                                              // see RULE_07
        chk_fire && eau_en && !f_trans && !f_remap |=> res_ea_update)
        else $error("extended accessed update missed");
    a_supervisor_exec_from_user_block_block: assert property (                                             // see RULE_08
        chk_fire && sxb_en && priv_eff && chk_exec && chk_walk_all_user && !f_trans
        |=> res_remap_fault)
        else $error("supervisor execute from user page allowed");
    a_xd_block: assert property (                                               // see RULE_09
        chk_fire && xdh_en && chk_exec && chk_walk_any_xd && !f_trans |=> res_remap_fault)
        else $error("execute-disable page fetched");
    a_wp_user: assert property (                                                // see RULE_10
        chk_fire && !priv_eff && !chk_exec && tt_known && !(fs_walk && lvl_bad)
        |=> !res_remap_fault)
        else $error("user request faulted by write protect");
    a_wp_block: assert property (                                               // see RULE_11
        chk_fire && swp_en && priv_eff && chk_write && chk_page_read_only && !f_trans
        |=> res_remap_fault)
        else $error("supervisor write to read-only page allowed");
    a_ere_block: assert property (                                              // see RULE_13
        chk_fire && chk_with_pasid && chk_exec && !ere_en && !f_trans |=> res_remap_fault)
        else $error("execute request allowed with enable clear");
    a_ignore_tt: assert property (                                              // see RULE_06
        chk_fire && tts_raw == PFD_TT_PASS && !chk_exec |=> !res_remap_fault)
        else $error("pass-through request faulted by first-stage enable");
    a_bus_answer: assert property (
        bus_req && bus_state == PFD_BUS_IDLE |=> !avs_waitrequest || !bus_req)
        else $error("bus answer later than one wait cycle");
    a_irq_level: assert property (
        ev_remap && mask[`PFD_ST_REMAP_BIT] |=> irq)
        else $error("masked-in event did not raise interrupt");
    a_res_pulse: assert property (
        res_valid == $past(chk_fire))
        else $error("result pulse not one cycle after acceptance");
    a_trans_quiet: assert property (                                            // see RULE_14
        chk_fire && f_trans |=> !res_remap_fault && !res_ea_update && !res_root_used)
        else $error("translation fault did not suppress other results");
    a_root_zero: assert property (                                              // see RULE_05
        chk_fire && !fs_walk |=> res_root == `PFD_ROOT_RESET)
        else $error("root passed without first-stage walk");
    a_fs_ignored: assert property (                                             // see RULE_06
        chk_fire && !fs_walk |=> !res_ea_update && !res_root_is_gpa)
        else $error("first-stage enable honoured without first-stage walk");
    a_xd_allow: assert property (                                               // see RULE_09
        chk_fire && !xdh_en && !sxb_en && chk_exec && !chk_write && (!chk_with_pasid || ere_en)
        && tt_known && !(fs_walk && lvl_bad) |=> !res_remap_fault)
        else $error("fetch blocked with execute-disable not honoured");
    a_wp_allow: assert property (                                               // see RULE_11
        chk_fire && !swp_en && chk_write && !chk_exec && tt_known && !(fs_walk && lvl_bad)
        |=> !res_remap_fault)
        else $error("write blocked with write protect clear");
    a_status_set: assert property (
        ev_vec != 3'h0 |=> (status & $past(ev_vec)) == $past(ev_vec))
        else $error("status event lost");
    a_mask_write: assert property (
        wr_en && hit_mask |=> {29'h0000_0000, mask} == ($past(mask_wr) & 32'h0000_0007))
        else $error("mask write did not land");

    c_remap: cover property (res_valid && res_remap_fault);
    c_trans: cover property (res_valid && res_trans_fault);
    c_nested: cover property (res_valid && res_root_is_gpa && res_ea_update);
    c_irq_clear: cover property (irq ##1 wr_en && hit_st ##1 !irq);
    c_five: cover property (res_valid && res_depth == `PFD_DEPTH_FIVE);

endmodule : pfd_entry_decode

`default_nettype wire

//--- testbench/pfd_endpoint_model.sv
// Purpose: endpoint model issuing checked memory requests
// Assumes: one request in flight, start delay chosen by the bench
// Notes:   valid and attributes held until taken; idle attributes invert
`timescale 1ns/1ps
`default_nettype none
module pfd_endpoint_model (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       req_go,
    input  wire logic [6:0] req_attr,
    input  wire logic [1:0] req_dly,
    input  wire logic       chk_ready,
    output var logic        chk_valid,
    output var logic [6:0]  chk_attr
);
    logic       pend = 1'b0;
    logic [1:0] cnt  = 2'h0;
    logic [6:0] held = 7'h00;
    // request held until the ready edge, then lines released
    always @(posedge mclk) begin
        if (rst) begin
            chk_valid <= 1'b0;
            chk_attr  <= 7'h00;
            pend      <= 1'b0;
        end else if (chk_valid && chk_ready) begin
            chk_valid <= 1'b0;
            chk_attr  <= ~chk_attr;
        end else if (req_go) begin
            pend <= 1'b1;
            cnt  <= req_dly;
            held <= req_attr;
        end else if (pend && cnt == 2'h0) begin
            chk_valid <= 1'b1;
            chk_attr  <= held;
            pend      <= 1'b0;
        end else if (pend) begin
            cnt <= cnt - 2'h1;
        end
    end
endmodule : pfd_endpoint_model
`default_nettype wire

//--- testbench/tb_top.sv
// Purpose: self-checking bench of the entry decoder
// Assumes: main instance with all capabilities, second instance with none
// Notes:   attribute order {pasid, priv, exec, write, all_user, any_xd, ro}
`timescale 1ns/1ps
`default_nettype none
`include "pfd_regs.svh"
module tb_top;
    import pfd_pkg::*;
    localparam logic [51:0] ROOT_VAL = 52'h000000ab12345;
    logic         mclk = 1'b0;
    logic         rst = 1'b1;
    logic [7:0]   avs_address = 8'h00;
    logic         avs_read = 1'b0;
    logic         avs_write = 1'b0;
    logic [31:0]  avs_writedata = 32'h0;
    logic [3:0]   avs_byteenable = 4'hf;
    logic [31:0]  avs_readdata, rd;
    logic         avs_waitrequest, chk_valid, chk_ready, res_valid, irq;
    logic         res_remap_fault, res_trans_fault, res_root_used, res_root_is_gpa, res_ea_update;
    logic [63:12] res_root;
    logic [2:0]   res_depth;
    logic [6:0]   chk_attr;
    logic         req_go = 1'b0;
    logic [6:0]   req_attr = 7'h00;
    logic [1:0]   req_dly = 2'h0;
    logic [7:0]   offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h1c};
    int           failures = 0;
    int           compares = 0;
    logic         n_valid, n_remap, n_trans, n_used, n_gpa, n_ea;
    logic [63:12] n_root;
    logic [2:0]   n_depth;

    pfd_entry_decode uut (.mclk(mclk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .chk_valid(chk_valid), .chk_ready(chk_ready),
        .chk_with_pasid(chk_attr[6]), .chk_privileged(chk_attr[5]), .chk_exec(chk_attr[4]),
        .chk_write(chk_attr[3]), .chk_walk_all_user(chk_attr[2]),
        .chk_walk_any_xd(chk_attr[1]), .chk_page_read_only(chk_attr[0]),
        .res_valid(res_valid), .res_remap_fault(res_remap_fault),
        .res_trans_fault(res_trans_fault), .res_root_used(res_root_used),
        .res_root_is_gpa(res_root_is_gpa), .res_root(res_root), .res_depth(res_depth),
        .res_ea_update(res_ea_update), .irq(irq));
    pfd_endpoint_model ep (.mclk(mclk), .rst(rst), .req_go(req_go), .req_attr(req_attr),
        .req_dly(req_dly), .chk_ready(chk_ready), .chk_valid(chk_valid), .chk_attr(chk_attr));
    // reduced build: no first-stage, five-level or accessed-flag support
    pfd_entry_decode #(.FS_SUPPORTED(1'b0), .FL5_SUPPORTED(1'b0), .EA_SUPPORTED(1'b0),
        .ADDR_W(8)) uut_nofs (.mclk(mclk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(), .avs_waitrequest(),
        .chk_valid(chk_valid), .chk_ready(),
        .chk_with_pasid(chk_attr[6]), .chk_privileged(chk_attr[5]), .chk_exec(chk_attr[4]),
        .chk_write(chk_attr[3]), .chk_walk_all_user(chk_attr[2]),
        .chk_walk_any_xd(chk_attr[1]), .chk_page_read_only(chk_attr[0]),
        .res_valid(n_valid), .res_remap_fault(n_remap), .res_trans_fault(n_trans),
        .res_root_used(n_used), .res_root_is_gpa(n_gpa), .res_root(n_root),
        .res_depth(n_depth), .res_ea_update(n_ea), .irq());

    initial begin
        forever #20 mclk = ~mclk;
    end

    task automatic err(input string m);
        failures++;
        $display("ERROR %0t %s", $time, m);
    endtask : err

    task automatic cmp_word(input logic [63:0] got, input logic [63:0] exp, input string m);
        compares++;
        if (got !== exp) err({m, " mismatch"});
    endtask : cmp_word

    task automatic cmp_res(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
        compares++;
        if ((got & m) !== (exp & m)) err($sformatf("result %h expected %h", got, exp));
    endtask : cmp_res

    // avalon transfer: held until the edge that samples waitrequest low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int n = 0;
        @(posedge mclk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= !w;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) err("bus timeout");
        r = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus

    task automatic sweep(input logic [31:0] ev [6]);
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, offs[i], 32'h0, rd);
            cmp_word({32'h0, rd}, {32'h0, ev[i]}, "register");
        end
    endtask : sweep

    task automatic cmp_irq(input logic e);
        @(negedge mclk);
        cmp_word({63'h0, irq}, {63'h0, e}, "irq");
    endtask : cmp_irq

    task automatic run_case(input logic [10:0] c, input logic [6:0] a);
        logic [2:0] tt;
        logic       used, trans, priv, remap, tn, rn;
        logic [7:0] e, m, en;
        int         n = 0;
        tt = c[2:0];
        used = (tt == 3'h1) || (tt == 3'h3);
        trans = (tt == 3'h0) || (tt > 3'h4) || (used && c[4]);
        priv = a[6] ? a[5] : c[10];
        remap = !trans && ((a[6] && a[4] && !c[9]) || (used && ((c[6] && priv && a[4] && a[2])
                || (c[7] && a[4] && a[1]) || (c[8] && priv && a[3] && a[0]))));
        e = {(c[4:3] == 2'h1) ? 3'h5 : 3'h4, c[5] && used && !trans && !remap,
             tt == 3'h3, used, trans, remap};
        m = trans ? 8'h03 : 8'hff;
        tn = (tt == 3'h0) || (tt > 3'h4);
        rn = !tn && a[6] && a[4] && !c[9];
        en = {e[7:5], 3'h0, tn, rn};
        bus(1'b1, `PFD_OFF_CFG, {21'h0, c}, rd);
        @(posedge mclk);
        req_go   <= 1'b1;
        req_attr <= a;
        req_dly  <= req_dly + 2'h1;
        @(posedge mclk);
        req_go <= 1'b0;
        do begin
            @(negedge mclk);
            n++;
        end while (res_valid !== 1'b1 && n < 20);
        if (n >= 20) err("no result");
        cmp_res({res_depth, res_ea_update, res_root_is_gpa, res_root_used, res_trans_fault,
                 res_remap_fault}, e, m);
        if (!trans) cmp_word({12'h0, res_root}, {12'h0, used ? ROOT_VAL : 52'h0}, "root");
        cmp_word({63'h0, n_valid}, 64'h1, "reduced valid");
        cmp_res({n_depth, n_ea, n_gpa, n_used, n_trans, n_remap}, en, 8'hff);
        cmp_word({12'h0, n_root}, 64'h0, "reduced root");
        bus(1'b0, `PFD_OFF_RESULT, 32'h0, rd);
        cmp_res(rd[7:0], e, m);
    endtask : run_case

    task automatic report_and_stop();
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (20000) @(posedge mclk);
        err("watchdog expired");
        report_and_stop();
    end

    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        sweep('{32'h0, 32'h0, 32'h0, 32'h7, 32'h0, 32'h0});
        bus(1'b1, `PFD_OFF_ROOT_LO, 32'h1234_5fff, rd);
        bus(1'b1, `PFD_OFF_ROOT_HI, 32'h0000_00ab, rd);
        bus(1'b1, `PFD_OFF_CAP, 32'h0, rd);
        bus(1'b1, 8'h1c, 32'hffff_ffff, rd);
        sweep('{32'h0, 32'h1234_5000, 32'hab, 32'h7, 32'h0, 32'h0});
        run_case(11'h201, 7'h40);
        run_case(11'h209, 7'h40);
        run_case(11'h3e2, 7'h7f);
        run_case(11'h3e4, 7'h7f);
        run_case(11'h203, 7'h40);
        run_case(11'h221, 7'h40);
        run_case(11'h261, 7'h74);
        run_case(11'h241, 7'h54);
        run_case(11'h201, 7'h52);
        run_case(11'h281, 7'h52);
        run_case(11'h701, 7'h49);
        run_case(11'h301, 7'h09);
        run_case(11'h701, 7'h09);
        run_case(11'h201, 7'h69);
        run_case(11'h301, 7'h69);
        run_case(11'h001, 7'h50);
        run_case(11'h002, 7'h50);
        run_case(11'h219, 7'h40);
        run_case(11'h200, 7'h40);
        run_case(11'h205, 7'h40);
        bus(1'b1, `PFD_OFF_STATUS, 32'h7, rd);
        bus(1'b1, `PFD_OFF_MASK, 32'h1, rd);
        run_case(11'h211, 7'h40);
        cmp_irq(1'b0);
        run_case(11'h281, 7'h52);
        cmp_irq(1'b1);
        bus(1'b1, `PFD_OFF_STATUS, 32'h1, rd);
        cmp_irq(1'b0);
        bus(1'b0, `PFD_OFF_STATUS, 32'h0, rd);
        cmp_word({32'h0, rd}, 64'h6, "status");
        bus(1'b1, `PFD_OFF_MASK, 32'h2, rd);
        cmp_irq(1'b1);
        bus(1'b1, `PFD_OFF_STATUS, 32'h2, rd);
        cmp_irq(1'b0);
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
